// File: include/dp_pkg.sv
// constants and types shared by the logic tile datapath
package dp_pkg;
    localparam int DW         = 8;
    localparam int FIFO_DEPTH = 4;
    localparam int NUM_OUT    = 6;
    localparam int SEL_W      = 4;
    localparam int CFG_W      = 18;

    // register word indices
    localparam logic [3:0] CTRL_IDX   = 4'h0;
    localparam logic [3:0] STATUS_IDX = 4'h1;
    localparam logic [3:0] STICKY_IDX = 4'h2;
    localparam logic [3:0] CFG_IDX    = 4'h3;
    localparam logic [3:0] MSB_IDX    = 4'h4;
    localparam logic [3:0] AMASK_IDX  = 4'h5;
    localparam logic [3:0] OMASK_IDX  = 4'h6;
    localparam logic [3:0] POLY_IDX   = 4'h7;
    localparam logic [3:0] CMASK_IDX  = 4'h8;
    localparam logic [3:0] OSEL_IDX   = 4'h9;
    localparam logic [3:0] SET0_IDX   = 4'ha;
    localparam logic [3:0] SET1_IDX   = 4'hb;
    localparam logic [3:0] FIFO0_IDX  = 4'hc;
    localparam logic [3:0] FIFO1_IDX  = 4'hd;
    localparam logic [3:0] FSTAT_IDX  = 4'he;

    // configuration word fields
    localparam int CFG_A_SRC = 0;
    localparam int CFG_B_SRC = 1;
    localparam int CFG_DST   = 3;
    localparam int CFG_SHIFT = 4;
    localparam int CFG_CIN   = 6;
    localparam int CFG_SEQ   = 8;
    localparam int CFG_TM    = 10;
    localparam int CFG_F0OUT = 11;
    localparam int CFG_PAIR  = 13;
    localparam int CFG_CHAIN = 15;
    localparam int CFG_SI    = 16;

    // routing input bits
    localparam int RIN_OP   = 0;
    localparam int RIN_SI   = 3;
    localparam int RIN_FIFO = 4;
    localparam int RIN_LOAD = 5;

    // reset values
    localparam logic [2:0]  MSB_RST   = 3'h7;
    localparam logic [7:0]  AMASK_RST = 8'hff;
    localparam logic [15:0] CMASK_RST = 16'hffff;
    localparam logic [23:0] OSEL_RST  = 24'h543210;

    typedef enum logic [2:0] {
        OP_PASS, OP_INC, OP_DEC, OP_ADD,
        OP_SUB, OP_XOR, OP_AND, OP_OR
    } alu_op_t;

    typedef enum logic [1:0] {
        SH_NONE, SH_LEFT, SH_RIGHT, SH_SWAP
    } shift_t;

    typedef enum logic [1:0] {
        SEQ_OFF, SEQ_CRC, SEQ_PRS, SEQ_RSVD
    } seq_t;
endpackage

// File: hw/configurable_logic_tile_datapath.sv
// 8-bit configurable datapath of a logic tile with avalon-mm registers
`timescale 1ns/10ps

// Notes on behaviour
// - shift left, right, nibble swap, or mask
// - two comparators, each with operand mask
// - comparator operand pairing is selectable
// - zero, all-ones and overflow detection
// - chosen conditions drive routing outputs
// - compares chain with neighbouring tiles
// - msb position is programmable
// - alu output mask for arbitrary widths
// - one crc or sequence step per clock
// - wide crc chains into neighbour tiles
// - two fifos of four bytes each
// - input fifo: bus writes, datapath reads
// - output fifo: datapath writes, bus reads
// - fifo status selectable as outputs
// - carry, shift and conditions chain outward
// - time multiplexing alternates two register sets
// - carry and shift out registered for reuse
// - two sets give sixteen-bit operations
// - each output picks condition or serial data
// - control register bits drive routing
// - read-only status shows routing signals
module configurable_logic_tile_datapath #(
    parameter int FIFO_DEPTH = dp_pkg::FIFO_DEPTH
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [3:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    input  wire logic [5:0]  route_in,
    output logic      [5:0]  route_out,
    input  wire logic [7:0]  status_in,
    output logic      [7:0]  ctrl_out,
    input  wire logic        chain_ci,
    input  wire logic        chain_si,
    input  wire logic [1:0]  chain_eq_in,
    input  wire logic [1:0]  chain_lt_in,
    output logic             chain_co,
    output logic             chain_so,
    output logic      [1:0]  chain_eq_out,
    output logic      [1:0]  chain_lt_out
);
    localparam int PW = $clog2(FIFO_DEPTH);
    localparam logic [PW:0] FULL_CNT = (PW + 1)'(FIFO_DEPTH);

    typedef struct packed {
        logic                                 ack;
        logic [31:0]                          rdata;
        logic [1:0]                           popok;
        logic [7:0]                           ctrl;
        logic [7:0]                           sticky;
        logic [7:0]                           smask;
        logic [dp_pkg::CFG_W-1:0]             cfg;
        logic [2:0]                           msb;
        logic [7:0]                           amask;
        logic [7:0]                           omask;
        logic [7:0]                           poly;
        logic [15:0]                          cmask;
        logic [23:0]                          osel;
        logic [1:0][31:0]                     regs;
        logic                                 set;
        logic                                 carry;
        logic                                 sout;
        logic [1:0][FIFO_DEPTH-1:0][7:0]      mem;
        logic [1:0][PW:0]                     wp;
        logic [1:0][PW:0]                     rp;
        logic [1:0][7:0]                      last;
        logic [5:0]                           rout;
    } state_t;

    localparam state_t RST_STATE = '{
        amask:   dp_pkg::AMASK_RST,
        msb:     dp_pkg::MSB_RST,
        cmask:   dp_pkg::CMASK_RST,
        osel:    dp_pkg::OSEL_RST,
        default: '0
    };

    state_t              q;
    state_t              d;
    logic                s;
    logic [7:0]          a0;
    logic [7:0]          a1;
    logic [7:0]          d0;
    logic [7:0]          d1;
    logic [7:0]          wm;
    logic [7:0]          srca;
    logic [7:0]          srcb;
    logic [7:0]          opb;
    logic                cin;
    logic                si;
    logic [8:0]          res9;
    logic [7:0]          alu;
    logic [7:0]          masked;
    logic [7:0]          result;
    logic                co;
    logic                so;
    logic                ov;
    logic                arith;
    logic                fb;
    logic                chain_en;
    dp_pkg::seq_t        seq;
    logic [1:0][7:0]     cx;
    logic [1:0][7:0]     cy;
    logic [1:0][7:0]     mk;
    logic [1:0]          eql;
    logic [1:0]          eq;
    logic [1:0]          lt;
    logic [1:0][PW:0]    cnt;
    logic [1:0]          empty;
    logic [1:0]          full;
    logic [1:0][7:0]     head;
    logic [1:0]          fout;
    logic [15:0]         cond;
    logic [5:0]          rsel;
    logic                req;
    logic                commit;
    logic [31:0]         cur;
    logic [31:0]         wv;
    logic [7:0]          stat_v;
    logic [31:0]         set_v;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // each routing output picks one of sixteen signals
    generate
        for (genvar g = 0; g < dp_pkg::NUM_OUT; g++) begin : g_osel
            assign rsel[g] = cond[q.osel[g*dp_pkg::SEL_W
                                         +: dp_pkg::SEL_W]];
        end
    endgenerate

    always_comb begin
        d        = q;
        s        = q.set;
        a0       = q.regs[s][7:0];
        a1       = q.regs[s][15:8];
        d0       = q.regs[s][23:16];
        d1       = q.regs[s][31:24];
        chain_en = q.cfg[dp_pkg::CFG_CHAIN];
        seq      = dp_pkg::seq_t'(q.cfg[dp_pkg::CFG_SEQ +: 2]);
        wm       = 8'hff >> (3'h7 - q.msb);

        srca = (q.cfg[dp_pkg::CFG_A_SRC] ? a1 : a0) & wm;
        case (q.cfg[dp_pkg::CFG_B_SRC +: 2])
            2'h0: srcb = d0 & wm;
            2'h1: srcb = d1 & wm;
            2'h2: srcb = a0 & wm;
            default: srcb = a1 & wm;
        endcase
        case (q.cfg[dp_pkg::CFG_CIN +: 2])
            2'h0: cin = 1'b0;
            2'h1: cin = 1'b1;
            2'h2: cin = chain_ci;
            default: cin = q.carry;
        endcase
        case (q.cfg[dp_pkg::CFG_SI +: 2])
            2'h0: si = route_in[dp_pkg::RIN_SI];
            2'h1: si = chain_si;
            default: si = q.sout;
        endcase

        // operation is chosen per cycle from routing
        opb   = srcb;
        arith = 1'b1;
        case (dp_pkg::alu_op_t'(route_in[dp_pkg::RIN_OP +: 3]))
            dp_pkg::OP_INC: begin
                opb  = 8'h01;
                res9 = {1'b0, srca} + 9'h001;
            end
            dp_pkg::OP_DEC: begin
                opb  = wm;
                res9 = {1'b0, srca} + {1'b0, wm};
            end
            dp_pkg::OP_ADD: begin
                res9 = {1'b0, srca} + {1'b0, srcb} + {8'h00, cin};
            end
            dp_pkg::OP_SUB: begin
                opb  = ~srcb & wm;
                res9 = {1'b0, srca} + {1'b0, opb} + {8'h00, cin};
            end
            dp_pkg::OP_XOR: begin
                arith = 1'b0;
                res9  = {1'b0, srca ^ srcb};
            end
            dp_pkg::OP_AND: begin
                arith = 1'b0;
                res9  = {1'b0, srca & srcb};
            end
            dp_pkg::OP_OR: begin
                arith = 1'b0;
                res9  = {1'b0, srca | srcb};
            end
            default: begin
                arith = 1'b0;
                res9  = {1'b0, srca};
            end
        endcase
        alu = res9[7:0] & wm;
        // carry leaves from the bit above the programmed msb
        co  = arith & res9[{1'b0, q.msb} + 4'h1];
        ov  = arith & (srca[q.msb] == opb[q.msb])
                    & (alu[q.msb] != srca[q.msb]);
        masked = alu & q.amask;

        case (dp_pkg::shift_t'(q.cfg[dp_pkg::CFG_SHIFT +: 2]))
            dp_pkg::SH_LEFT: begin
                result = ((masked << 1) | {7'h00, si}) & wm;
                so     = masked[q.msb];
            end
            dp_pkg::SH_RIGHT: begin
                result = (masked >> 1) | ({7'h00, si} << q.msb);
                so     = masked[0];
            end
            dp_pkg::SH_SWAP: begin
                result = {masked[3:0], masked[7:4]};
                so     = 1'b0;
            end
            default: begin
                result = masked;
                so     = 1'b0;
            end
        endcase
        result = result | q.omask;

        // one lfsr step; prs ignores the serial input
        fb = srca[q.msb] ^ ((seq == dp_pkg::SEQ_CRC) & si);
        if (seq == dp_pkg::SEQ_CRC || seq == dp_pkg::SEQ_PRS) begin
            result = ((srca << 1) | {7'h00, chain_en & chain_si})
                   & wm;
            result = result ^ (fb ? (q.poly & wm) : 8'h00);
            so     = srca[q.msb];
        end

        case (q.cfg[dp_pkg::CFG_PAIR +: 2])
            2'h0: begin
                cx = {a1, a0};
                cy = {d1, d0};
            end
            2'h1: begin
                cx = {d0, a0};
                cy = {d1, a1};
            end
            2'h2: begin
                cx = {a0, a0};
                cy = {d1, d0};
            end
            default: begin
                cx = {a1, a1};
                cy = {d1, d0};
            end
        endcase
        mk = q.cmask;
        for (int n = 0; n < 2; n++) begin
            eql[n] = ((cx[n] ^ cy[n]) & mk[n]) == 8'h00;
            // a lower tile's result decides when this byte ties
            eq[n]  = eql[n] & (~chain_en | chain_eq_in[n]);
            lt[n]  = ((cx[n] & mk[n]) < (cy[n] & mk[n]))
                   | (eql[n] & chain_en & chain_lt_in[n]);
        end

        for (int n = 0; n < 2; n++) begin
            cnt[n]   = q.wp[n] - q.rp[n];
            empty[n] = cnt[n] == '0;
            full[n]  = cnt[n] == FULL_CNT;
            head[n]  = q.mem[n][q.rp[n][PW-1:0]];
            fout[n]  = q.cfg[dp_pkg::CFG_F0OUT + n];
        end

        cond = {q.sout, full[1], empty[1], full[0], empty[0],
                so, co, ov,
                (a1 | ~wm) == 8'hff, (a0 | ~wm) == 8'hff,
                (a1 & wm) == 8'h00, (a0 & wm) == 8'h00,
                lt[1], eq[1], lt[0], eq[0]};
        d.rout = rsel;

        // datapath side: load and fifo strobe
        if (route_in[dp_pkg::RIN_LOAD]) begin
            if (q.cfg[dp_pkg::CFG_DST]) begin
                d.regs[s][15:8] = result;
            end else begin
                d.regs[s][7:0] = result;
            end
            d.carry = co;
            d.sout  = so;
        end
        // time multiplexing alternates the register set
        d.set = q.cfg[dp_pkg::CFG_TM] & ~q.set;

        for (int n = 0; n < 2; n++) begin
            if (route_in[dp_pkg::RIN_FIFO]) begin
                if (fout[n] && !full[n]) begin
                    d.mem[n][q.wp[n][PW-1:0]] = n == 0 ? a0 : a1;
                    d.wp[n] = q.wp[n] + 1'b1;
                end else if (!fout[n]) begin
                    // an empty pop repeats the last byte
                    d.regs[s][16 + n*8 +: 8] = empty[n] ? q.last[n]
                                                        : head[n];
                    if (!empty[n]) begin
                        d.rp[n]   = q.rp[n] + 1'b1;
                        d.last[n] = head[n];
                    end
                end
            end
        end

        // bus side: one wait cycle, effects at the answering edge
        req    = read | write;
        commit = req & q.ack;
        d.ack  = req & ~q.ack;
        // live bits always show, so a condition that just rose is not hidden
        stat_v = status_in | (q.sticky & q.smask);
        set_v  = address == dp_pkg::SET1_IDX ? q.regs[1] : q.regs[0];
        case (address)
            dp_pkg::CTRL_IDX:   cur = {24'h000000, q.ctrl};
            dp_pkg::STATUS_IDX: cur = {24'h000000, stat_v};
            dp_pkg::STICKY_IDX: cur = {24'h000000, q.smask};
            dp_pkg::CFG_IDX:    cur = {14'h0000, q.cfg};
            dp_pkg::MSB_IDX:    cur = {29'h00000000, q.msb};
            dp_pkg::AMASK_IDX:  cur = {24'h000000, q.amask};
            dp_pkg::OMASK_IDX:  cur = {24'h000000, q.omask};
            dp_pkg::POLY_IDX:   cur = {24'h000000, q.poly};
            dp_pkg::CMASK_IDX:  cur = {16'h0000, q.cmask};
            dp_pkg::OSEL_IDX:   cur = {8'h00, q.osel};
            dp_pkg::SET0_IDX,
            dp_pkg::SET1_IDX:   cur = set_v;
            dp_pkg::FIFO0_IDX:  cur = {24'h000000,
                                       empty[0] ? q.last[0] : head[0]};
            dp_pkg::FIFO1_IDX:  cur = {24'h000000,
                                       empty[1] ? q.last[1] : head[1]};
            dp_pkg::FSTAT_IDX:  cur = {16'h0000, 4'(cnt[1]), 4'(cnt[0]),
                                       4'h0, full[1], empty[1],
                                       full[0], empty[0]};
            default:            cur = 32'h00000000;
        endcase
        wv = merge(cur, writedata, byteenable);

        if (req && !q.ack) begin
            d.rdata = read ? cur : 32'h00000000;
            for (int n = 0; n < 2; n++) begin
                // pop only the byte that was actually shown
                d.popok[n] = read & fout[n] & ~empty[n]
                           & (address == (n == 0 ? dp_pkg::FIFO0_IDX
                                                 : dp_pkg::FIFO1_IDX));
            end
        end

        // set wins: only bits reported by this read are cleared
        d.sticky = q.sticky & q.smask;
        if (commit && read && address == dp_pkg::STATUS_IDX) begin
            d.sticky = d.sticky & ~q.rdata[7:0];
        end
        d.sticky = d.sticky | (status_in & q.smask);

        if (commit && read) begin
            for (int n = 0; n < 2; n++) begin
                if (q.popok[n]) begin
                    d.rp[n]   = q.rp[n] + 1'b1;
                    d.last[n] = head[n];
                end
            end
        end

        if (commit && write) begin
            case (address)
                dp_pkg::CTRL_IDX:   d.ctrl  = wv[7:0];
                dp_pkg::STICKY_IDX: d.smask = wv[7:0];
                dp_pkg::CFG_IDX:    d.cfg   = wv[dp_pkg::CFG_W-1:0];
                dp_pkg::MSB_IDX:    d.msb   = wv[2:0];
                dp_pkg::AMASK_IDX:  d.amask = wv[7:0];
                dp_pkg::OMASK_IDX:  d.omask = wv[7:0];
                dp_pkg::POLY_IDX:   d.poly  = wv[7:0];
                dp_pkg::CMASK_IDX:  d.cmask = wv[15:0];
                dp_pkg::OSEL_IDX:   d.osel  = wv[23:0];
                dp_pkg::SET0_IDX:   d.regs[0] = wv;
                dp_pkg::SET1_IDX:   d.regs[1] = wv;
                dp_pkg::FIFO0_IDX,
                dp_pkg::FIFO1_IDX: begin
                    for (int n = 0; n < 2; n++) begin
                        if (address[0] == n[0] && !fout[n]
                            && !full[n] && byteenable[0]) begin
                            d.mem[n][q.wp[n][PW-1:0]] = writedata[7:0];
                            d.wp[n] = q.wp[n] + 1'b1;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= RST_STATE;
        end else begin
            q <= d;
        end
    end

    assign readdata     = q.rdata;
    assign waitrequest  = (read | write) & ~q.ack;
    assign route_out    = q.rout;
    assign ctrl_out     = q.ctrl;
    // chain outputs stay combinational so a wide compare settles in a cycle
    assign chain_co     = co;
    assign chain_so     = so;
    assign chain_eq_out = eq;
    assign chain_lt_out = lt;
endmodule

// File: verif/dp_asserts.sv
// concurrent checks on the datapath register bus and control port
`timescale 1ns/10ps
module dp_asserts #(
    parameter int FIFO_DEPTH = 4
) (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [3:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [3:0]  byteenable,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic [7:0]  status_in,
    input wire logic [7:0]  ctrl_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic       req;
    logic [7:0] wd_lo;
    assign req   = read | write;
    assign wd_lo = writedata[7:0];

    a_wait_first: assert property (req && !$past(req) |-> waitrequest)
        else $error("no wait cycle at start of access");
    a_wait_one: assert property (waitrequest |=> !waitrequest)
        else $error("more than one wait cycle");
    a_wait_idle: assert property (!req |-> !waitrequest)
        else $error("wait raised with no access");
    a_unmapped_zero: assert property (
        read && !waitrequest && address == 4'hf |-> readdata == 32'h0)
        else $error("unmapped read not zero");
    a_ctrl_write: assert property (
        write && !waitrequest && address == dp_pkg::CTRL_IDX && byteenable[0]
        |=> ctrl_out == $past(wd_lo))
        else $error("control write not applied");
    a_ctrl_hold: assert property (
        !(write && !waitrequest && address == dp_pkg::CTRL_IDX)
        |=> $stable(ctrl_out))
        else $error("control changed without a write");
    a_rdata_hold: assert property (
        !(req && waitrequest) |=> $stable(readdata))
        else $error("read data moved between accesses");
    a_status_direct: assert property (
        read && waitrequest && address == dp_pkg::STATUS_IDX
        |=> (readdata[7:0] & $past(status_in)) == $past(status_in))
        else $error("status read lost a live routed bit");
endmodule

// File: verif/route_model.sv
// routing matrix stand-in feeding the tile's routing and chain inputs
`timescale 1ns/10ps
module route_model (
    input  wire logic       clk,
    output logic      [5:0] route_in,
    output logic      [7:0] status_in,
    output logic            chain_ci,
    output logic            chain_si,
    output logic      [1:0] chain_eq_in,
    output logic      [1:0] chain_lt_in
);
    // lower tile reports equal and not less, so chaining is transparent
    initial begin
        route_in    = 6'h00;
        status_in   = 8'h00;
        chain_ci    = 1'b0;
        chain_si    = 1'b0;
        chain_eq_in = 2'h3;
        chain_lt_in = 2'h0;
    end

    // op, serial in, fifo strobe and load for one evaluation cycle
    task automatic step(input logic [5:0] v);
        route_in <= v;
        @(posedge clk);
        route_in <= 6'h00;
        @(posedge clk);
    endtask

    // routing and chain inputs, held until the next call
    task automatic drive(input logic [5:0] v, input logic [1:0] c,
                         input logic [1:0] eq, input logic [1:0] lt);
        route_in    <= v;
        chain_ci    <= c[1];
        chain_si    <= c[0];
        chain_eq_in <= eq;
        chain_lt_in <= lt;
    endtask

    task automatic put_status(input logic [7:0] v);
        status_in <= v;
        @(posedge clk);
    endtask
endmodule

// File: verif/configurable_logic_tile_datapath_tb_top.sv
// self-checking bench for the logic tile datapath
`timescale 1ns/10ps
module configurable_logic_tile_datapath_tb_top;
    localparam int FD = dp_pkg::FIFO_DEPTH;
    logic        clk, rst, read, write, waitrequest, chain_ci, chain_si;
    logic        chain_co, chain_so;
    logic [3:0]  address, byteenable;
    logic [31:0] writedata, readdata;
    logic [5:0]  route_in, route_out;
    logic [7:0]  status_in, ctrl_out;
    logic [1:0]  chain_eq_in, chain_lt_in, chain_eq_out, chain_lt_out;
    int          fail_count;
    int          checked;

    configurable_logic_tile_datapath #(.FIFO_DEPTH(FD)) DUT (
        .clk(clk), .rst(rst), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest),
        .route_in(route_in), .route_out(route_out),
        .status_in(status_in), .ctrl_out(ctrl_out),
        .chain_ci(chain_ci), .chain_si(chain_si),
        .chain_eq_in(chain_eq_in), .chain_lt_in(chain_lt_in),
        .chain_co(chain_co), .chain_so(chain_so),
        .chain_eq_out(chain_eq_out), .chain_lt_out(chain_lt_out));
    route_model u_route (
        .clk(clk), .route_in(route_in), .status_in(status_in),
        .chain_ci(chain_ci), .chain_si(chain_si),
        .chain_eq_in(chain_eq_in), .chain_lt_in(chain_lt_in));

    always #2.5 clk = ~clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // the request stands until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr_en, input logic [3:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        address   <= a;
        writedata <= d;
        write     <= wr_en;
        read      <= ~wr_en;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 40);
        if (n >= 40) fail_count++;
        q = readdata;
        read  <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rc(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask

    task automatic t_reset_vals;
        rc(dp_pkg::CTRL_IDX, 32'h0);
        rc(dp_pkg::MSB_IDX, {29'h0, dp_pkg::MSB_RST});
        rc(dp_pkg::AMASK_IDX, {24'h0, dp_pkg::AMASK_RST});
        rc(dp_pkg::CMASK_IDX, {16'h0, dp_pkg::CMASK_RST});
        rc(dp_pkg::OSEL_IDX, {8'h0, dp_pkg::OSEL_RST});
        rc(dp_pkg::FSTAT_IDX, 32'h5);
    endtask

    task automatic t_ctrl_status;
        wr(dp_pkg::CTRL_IDX, 32'ha5);
        chk({24'h0, ctrl_out}, 32'ha5);
        wr(4'hf, 32'h5a);
        rc(4'hf, 32'h0);
        rc(dp_pkg::CTRL_IDX, 32'ha5);
        u_route.put_status(8'h5a);
        wr(dp_pkg::STATUS_IDX, 32'hff);
        rc(dp_pkg::STATUS_IDX, 32'h5a);
        u_route.put_status(8'h00);
        wr(dp_pkg::STICKY_IDX, 32'h01);
        u_route.put_status(8'h01);
        u_route.put_status(8'h00);
        rc(dp_pkg::STATUS_IDX, 32'h01);
        rc(dp_pkg::STATUS_IDX, 32'h00);
    endtask

    task automatic t_alu;
        logic [7:0] a;
        wr(dp_pkg::SET0_IDX, 32'h0);
        @(posedge clk);
        chk({26'h0, route_out}, 32'h35);
        wr(dp_pkg::SET0_IDX, 32'h0005_0003);
        @(posedge clk);
        chk({26'h0, route_out}, 32'h26);
        u_route.step(6'h23);
        rc(dp_pkg::SET0_IDX, 32'h0005_0008);
        a = 8'h08;
        for (int s = 1; s < 4; s++) begin
            wr(dp_pkg::CFG_IDX, 32'(s) << dp_pkg::CFG_SHIFT);
            u_route.step(6'h20);
            case (s)
                1: a = {a[6:0], 1'b0};
                2: a = {1'b0, a[7:1]};
                default: a = {a[3:0], a[7:4]};
            endcase
            rc(dp_pkg::SET0_IDX, {24'h000500, a});
        end
        wr(dp_pkg::CFG_IDX, 32'h0);
        wr(dp_pkg::AMASK_IDX, 32'h3f);
        wr(dp_pkg::OMASK_IDX, 32'h01);
        u_route.step(6'h20);
        rc(dp_pkg::SET0_IDX, 32'h0005_0001);
    endtask

    // one write more than the depth must be dropped, one pop more
    // than the depth must repeat the last byte
    task automatic t_fifo;
        logic [7:0] e;
        wr(dp_pkg::OSEL_IDX, 32'h0054_321b);
        for (int i = 0; i <= FD; i++)
            wr(dp_pkg::FIFO0_IDX, 32'h10 + 32'(i));
        rc(dp_pkg::FSTAT_IDX, {20'h0, 4'(FD), 8'h06});
        chk({31'h0, route_out[0]}, 32'h0);
        for (int i = 0; i <= FD; i++) begin
            u_route.step(6'h10);
            e = 8'h10 + 8'((i < FD) ? i : FD - 1);
            rc(dp_pkg::SET0_IDX, {8'h0, e, 16'h0001});
        end
        rc(dp_pkg::FSTAT_IDX, 32'h5);
        chk({31'h0, route_out[0]}, 32'h1);
    endtask

    // byte 1 ties here and the lower tile claims less; carry and shift come in
    task automatic t_chain;
        logic [5:0] v;
        wr(dp_pkg::CFG_IDX, 32'h8280);
        wr(dp_pkg::SET0_IDX, 32'h0000_00ff);
        u_route.drive(6'h23, 2'h3, 2'h0, 2'h3);
        @(negedge clk);
        v = {chain_co, chain_so, chain_eq_out, chain_lt_out};
        chk({26'h0, v}, 32'h32);
        @(posedge clk);
        u_route.drive(6'h00, 2'h0, 2'h3, 2'h0);
        rc(dp_pkg::SET0_IDX, 32'h0000_00ff);
    endtask

    task automatic end_of_test;
        if (fail_count == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        fail_count = 0;
        checked    = 0;
        clk        = 1'b0;
        rst        = 1'b1;
        address    = 4'h0;
        read       = 1'b0;
        write      = 1'b0;
        writedata  = 32'h0;
        byteenable = 4'hf;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset_vals();
        t_ctrl_status();
        t_alu();
        t_fifo();
        t_chain();
        end_of_test();
    end

    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        end_of_test();
    end
endmodule

bind configurable_logic_tile_datapath dp_asserts #(
    .FIFO_DEPTH(FIFO_DEPTH)) u_chk (
    .clk(clk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .status_in(status_in), .ctrl_out(ctrl_out));
